// File: hdl/link_timer_params.svh
// timing constants for the link pulse and jabber timers
`ifndef LINK_TIMER_PARAMS_SVH
`define LINK_TIMER_PARAMS_SVH
`define CLK_PERIOD_PS      10000
`define JABBER_ON_MS       85
`define JABBER_OFF_MS      500
`define PULSE_WIDTH_NS     100
`define NLP_PERIOD_MS      16
`define FLP_CLK_PERIOD_US  125
`define FLP_DATA_DELAY_US  62
`define FLP_BURST_MS       2
`define FLP_PERIOD_MS      16
`define ENERGY_ON_MAX_MS   1
`define ENERGY_OFF_MAX_US  350
`define BREAK_LINK_MS      1500
`define FLP_CLOCK_PULSES   17
`define FLP_WORD_BITS      16
`define NS_TO_CYC(t)       ((((t) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define US_TO_CYC(t)       (((t) * 1000000) / `CLK_PERIOD_PS)
`define MS_TO_CYC(t)       (32'(((t) * 64'd1000000000) / `CLK_PERIOD_PS))
`endif

// File: hdl/link_timer_pkg.sv
// types shared by the link pulse and jabber timers
package link_timer_pkg;
  typedef enum logic [1:0] {pulse_idle, pulse_nlp, pulse_flp, pulse_break} pulse_mode_t;
  typedef logic [31:0] tick_t;
endpackage

// File: hdl/energy_qualifier.sv
// filters the raw line energy level into a bounded detect indication
`timescale 1ns/1ps
module energy_qualifier #(
  parameter int unsigned ON_CYC  = 100000,
  parameter int unsigned OFF_CYC = 35000
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic enable_100,
  input  wire logic energy_raw,
  output logic      line_energy_detect
);
  import link_timer_pkg::*;

  typedef struct packed {
    logic  s1;
    logic  s2;
    tick_t cnt;
    logic  det;
  } eq_state_t;

  eq_state_t q, d;

  always_comb begin
    d = q;
    d.s1 = energy_raw;
    d.s2 = q.s1;
    if (!enable_100) begin
      d.det = 1'b0;
      d.cnt = '0;
    end else if (q.s2 == q.det) begin
      d.cnt = '0;
    end else if (q.s2 && q.cnt >= tick_t'(ON_CYC - 1)) begin
      d.det = 1'b1;
      d.cnt = '0;
    end else if (!q.s2 && q.cnt >= tick_t'(OFF_CYC - 1)) begin
      d.det = 1'b0;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + tick_t'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign line_energy_detect = q.det;
endmodule // energy_qualifier

// File: hdl/link_pulse_jabber_timers.sv
// link pulse, fast link pulse burst, jabber and signal detect timers
`timescale 1ns/1ps
`include "link_timer_params.svh"

// How it works
// - 10 Mb/s transmit active continuously 85 ms enters jabber, cutting transmission.
// - jabber holds transmission off 500 ms, then releases it.
// - each normal link pulse lasts 100 ns.
// - idle 10BASE-T repeats normal link pulses every 16 ms.
// - every clock and data pulse in a burst is 100 ns wide.
// - clock pulses within a burst are 125 us apart.
// - a one puts a data pulse 62 us after its clock pulse; zero sends none.
// - a burst spans 2 ms from first pulse to last.
// - bursts start 16 ms apart during negotiation.
// - 100BASE-TX energy detect asserts within 1 ms of signal; the code asserts it 1 ms plus 2 mclk cycles after.
// - 100BASE-TX energy detect deasserts within 350 us of signal loss; the code deasserts it 350 us plus 2 mclk cycles after.
// - renegotiation silences all transmit and pulses 1500 ms, then bursts resume.
module link_pulse_jabber_timers #(
  parameter int unsigned JABBER_ON_CYC  = `MS_TO_CYC(`JABBER_ON_MS),
  parameter int unsigned JABBER_OFF_CYC = `MS_TO_CYC(`JABBER_OFF_MS),
  parameter int unsigned NLP_CYC        = `MS_TO_CYC(`NLP_PERIOD_MS),
  parameter int unsigned FLP_CLK_CYC    = `US_TO_CYC(`FLP_CLK_PERIOD_US),
  parameter int unsigned FLP_DATA_CYC   = `US_TO_CYC(`FLP_DATA_DELAY_US),
  parameter int unsigned FLP_PERIOD_CYC = `MS_TO_CYC(`FLP_PERIOD_MS),
  parameter int unsigned BREAK_CYC      = `MS_TO_CYC(`BREAK_LINK_MS),
  parameter int unsigned ENERGY_ON_CYC  = `MS_TO_CYC(`ENERGY_ON_MAX_MS),
  parameter int unsigned ENERGY_OFF_CYC = `US_TO_CYC(`ENERGY_OFF_MAX_US)
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mode_10,
  input  wire logic        mode_100,
  input  wire logic        autoneg_en,
  input  wire logic        renegotiate,
  input  wire logic [15:0] code_word,
  input  wire logic        tx_active,
  input  wire logic        energy_raw,
  output logic             tx_allowed,
  output logic             jabber,
  output logic             link_pulse,
  output logic             burst_active,
  output logic             break_link,
  output logic             line_energy_detect
);
  import link_timer_pkg::*;

  // every pulse, normal or inside a burst, is this many mclk cycles wide
  localparam tick_t       PW_CYC   = tick_t'(`NS_TO_CYC(`PULSE_WIDTH_NS));
  // index of the closing clock pulse; no data slot follows it
  localparam logic [4:0]  LAST_CLK = 5'(`FLP_CLOCK_PULSES - 1);
  localparam logic [4:0]  IDX_STEP = 5'd1;
  localparam int unsigned WORD_W   = `FLP_WORD_BITS;
  // offsets of the clock and data slots inside one clock pulse interval
  localparam tick_t       CLK_AT   = '0;
  localparam tick_t       DATA_AT  = tick_t'(FLP_DATA_CYC);

  typedef logic [WORD_W-1:0] word_t;

  typedef struct packed {
    logic        tx_s1;
    logic        tx_s2;
    logic        jab;
    tick_t       jcnt;
    pulse_mode_t mode;
    tick_t       pcnt;
    tick_t       scnt;
    logic [4:0]  clk_idx;
    word_t       word;
    logic        pulse;
  } tm_state_t;

  tm_state_t q, d;

  // counters start from zero, so a limit of lim is reached when they show lim - 1
  function automatic logic hit(input tick_t c, input int unsigned lim);
    hit = (c >= tick_t'(lim - 1));
  endfunction

  // true while a counter lies inside a pulse that begins at count start
  function automatic logic in_pulse(input tick_t c, input tick_t start);
    in_pulse = (c >= start) && (c < start + PW_CYC);
  endfunction

  // a burst runs from the cycle after its start until the closing clock slot ends
  function automatic logic in_burst(input tick_t pc, input logic [4:0] idx);
    in_burst = (pc != '0) && (idx <= LAST_CLK);
  endfunction

  always_comb begin
    logic clk_hit;
    logic data_hit;
    clk_hit  = 1'b0;
    data_hit = 1'b0;

    d = q;
    d.tx_s1 = tx_active;
    d.tx_s2 = q.tx_s1;
    d.pulse = 1'b0;
    // jabber watchdog: only an unbroken run of transmit counts toward the
    // limit; once tripped, the hold-off runs its full length whatever the
    // transmitter does
    if (!mode_10) begin
      d.jab  = 1'b0;
      d.jcnt = '0;
    end else if (!q.jab) begin
      if (!q.tx_s2) begin
        d.jcnt = '0;
      end else if (hit(q.jcnt, JABBER_ON_CYC)) begin
        d.jab  = 1'b1;
        d.jcnt = '0;
      end else begin
        d.jcnt = q.jcnt + tick_t'(1);
      end
    end else if (hit(q.jcnt, JABBER_OFF_CYC)) begin
      d.jab  = 1'b0;
      d.jcnt = '0;
    end else begin
      d.jcnt = q.jcnt + tick_t'(1);
    end
    // pulse generator: pcnt spaces bursts or nlps, scnt times within a burst
    d.pcnt = q.pcnt + tick_t'(1);
    unique case (q.mode)
      pulse_idle: begin
        d.pcnt = '0;
        if (autoneg_en) begin
          d.mode = pulse_flp;
        end else if (mode_10) begin
          d.mode = pulse_nlp;
        end
      end
      pulse_nlp: begin
        if (!mode_10 || autoneg_en) begin
          d.mode = pulse_idle;
        end else begin
          // a pulse starts only while the transmitter is quiet and, once started,
          // runs its full width so the far end never sees a runt
          if (q.pcnt == '0) begin
            d.pulse = !q.tx_s2;
          end else begin
            d.pulse = q.pulse && in_pulse(q.pcnt, CLK_AT);
          end
          if (hit(q.pcnt, NLP_CYC)) begin
            d.pcnt = '0;
          end
        end
      end
      pulse_flp: begin
        if (!autoneg_en) begin
          d.mode = pulse_idle;
        end else begin
          if (q.pcnt == '0) begin
            // the word is taken once per burst so a change mid-burst cannot tear it
            d.word    = code_word;
            d.clk_idx = '0;
            d.scnt    = '0;
          end else if (in_burst(q.pcnt, q.clk_idx)) begin
            d.scnt = q.scnt + tick_t'(1);
            if (hit(q.scnt, FLP_CLK_CYC)) begin
              d.scnt    = '0;
              d.clk_idx = q.clk_idx + IDX_STEP;
              d.word    = q.word >> 1;
            end
          end
          if (in_burst(q.pcnt, q.clk_idx)) begin
            clk_hit  = in_pulse(q.scnt, CLK_AT);
            data_hit = q.word[0] && in_pulse(q.scnt, DATA_AT);
            // the closing clock pulse ends the burst and carries no data slot
            if (q.clk_idx == LAST_CLK) begin
              data_hit = 1'b0;
            end
            d.pulse = clk_hit || data_hit;
          end
          if (hit(q.pcnt, FLP_PERIOD_CYC)) begin
            d.pcnt = '0;
          end
        end
      end
      pulse_break: begin
        if (hit(q.pcnt, BREAK_CYC)) begin
          d.mode = pulse_flp;
          d.pcnt = '0;
        end
      end
    endcase
    // a renegotiation request overrides every mode above and restarts the
    // break timer; a held request keeps it restarting
    if (renegotiate && autoneg_en) begin
      d.mode  = pulse_break;
      d.pcnt  = '0;
      d.pulse = 1'b0;
    end
  end

  // one register bank for the jabber and pulse timers (energy detect has its own in u_energy); reset returns them to idle
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // 100BASE-TX energy detect, bounded by its own on and off timers
  energy_qualifier #(
    .ON_CYC  (ENERGY_ON_CYC),
    .OFF_CYC (ENERGY_OFF_CYC)
  ) u_energy (
    .mclk               (mclk),
    .rst                (rst),
    .enable_100         (mode_100),
    .energy_raw         (energy_raw),
    .line_energy_detect (line_energy_detect)
  );

  assign jabber       = q.jab;
  assign break_link   = (q.mode == pulse_break);
  // the transmitter may drive the cable only outside jabber and break-link
  assign tx_allowed   = !q.jab && !break_link;
  assign link_pulse   = q.pulse;
  // status only: high from the first clock slot of a burst until its closing slot ends
  assign burst_active = (q.mode == pulse_flp) && in_burst(q.pcnt, q.clk_idx);
endmodule // link_pulse_jabber_timers

// File: testbench/link_partner_model.sv
// far-end transceiver model: drives energy onto the receive pair
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic sig_on,
  output logic      energy_raw
);
  assign energy_raw = sig_on;
endmodule // link_partner_model

// File: testbench/link_pulse_jabber_timers_assertions.sv
// assertions on the timer outputs
`timescale 1ns/1ps
module timers_chk #(parameter int unsigned JABBER_OFF_CYC = 300, BREAK_CYC = 400,
  ENERGY_ON_CYC = 40, ENERGY_OFF_CYC = 20) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic energy_raw,
  input wire logic tx_allowed,
  input wire logic jabber,
  input wire logic link_pulse,
  input wire logic break_link,
  input wire logic line_energy_detect
);
  localparam int J1 = JABBER_OFF_CYC - 1;
  localparam int B1 = BREAK_CYC - 1;
  localparam int EON = ENERGY_ON_CYC + 3;
  localparam int EOFF = ENERGY_OFF_CYC + 3;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  pulse_width_a: assert property ($rose(link_pulse) |-> ##9 link_pulse ##1 !link_pulse) else $error("width");
  jabber_hold_a: assert property ($rose(jabber) |-> ##J1 jabber ##1 !jabber) else $error("jabber");
  tx_gate_a: assert property (tx_allowed == !(jabber || break_link)) else $error("gate");
  break_quiet_a: assert property (break_link |-> !link_pulse) else $error("quiet");
  break_len_a: assert property ($rose(break_link) |-> ##[B1:B1] break_link ##1 !break_link) else $error("break");
  energy_on_a: assert property ($rose(energy_raw) |-> ##[1:EON] (line_energy_detect || !energy_raw)) else $error("on");
  energy_off_a: assert property ($fell(energy_raw) |-> ##[1:EOFF] !line_energy_detect) else $error("off");
  reset_idle_a: assert property ($fell(rst) |-> tx_allowed && !jabber && !link_pulse && !break_link) else $error("rst");
  cover property ($rose(jabber));
  cover property ($rose(break_link));
  cover property ($rose(line_energy_detect));
endmodule // timers_chk
bind link_pulse_jabber_timers timers_chk #(.JABBER_OFF_CYC(JABBER_OFF_CYC), .BREAK_CYC(BREAK_CYC),
  .ENERGY_ON_CYC(ENERGY_ON_CYC), .ENERGY_OFF_CYC(ENERGY_OFF_CYC)) chk (.mclk, .rst, .energy_raw, .tx_allowed,
  .jabber, .link_pulse, .break_link, .line_energy_detect);

// File: testbench/link_pulse_jabber_timers_tb.sv
// self-checking bench for the link pulse and jabber timers
`timescale 1ns/1ps
module link_pulse_jabber_timers_tb;
  logic        mclk = 0, rst = 1, mode_10 = 0, mode_100 = 0, autoneg_en = 0, renegotiate = 0, tx_active = 0;
  logic        sig_on = 0, energy_raw, tx_allowed, jabber, link_pulse, break_link, line_energy_detect;
  logic [15:0] code_word = 16'ha5c3;
  int          errors = 0, n_compared = 0, n, q[$];
  logic        burst_active;
  localparam int unsigned JON = 200, JOFF = 300, NLP = 500, FCLK = 50, FDAT = 25, FPER = 1200, BRK = 400;
  localparam int unsigned EON = 40, EOFF = 20, PW = 10;
  initial forever #5 mclk = ~mclk;
  link_partner_model lp (.sig_on, .energy_raw);
  link_pulse_jabber_timers #(.JABBER_ON_CYC(JON), .JABBER_OFF_CYC(JOFF), .NLP_CYC(NLP), .FLP_CLK_CYC(FCLK),
    .FLP_DATA_CYC(FDAT), .FLP_PERIOD_CYC(FPER), .BREAK_CYC(BRK), .ENERGY_ON_CYC(EON), .ENERGY_OFF_CYC(EOFF)) DUT (
    .mclk, .rst, .mode_10, .mode_100, .autoneg_en, .renegotiate, .code_word, .tx_active, .energy_raw,
    .tx_allowed, .jabber, .link_pulse, .burst_active, .break_link, .line_energy_detect);
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts falling edges until the chosen output reaches v
  task automatic till(int s, logic v);
    n = 0;
    while ((s == 0 ? link_pulse : s == 1 ? jabber : s == 2 ? break_link : line_energy_detect) !== v) begin
      @(negedge mclk);
      n++;
      if (n > 5000) begin
        errors++;
        complete_run();
      end
    end
  endtask
  task automatic restart();
    @(negedge mclk) {mode_10, mode_100, autoneg_en, tx_active, sig_on, rst} = 6'h01;
    repeat (2) @(negedge mclk);
    rst = 0;
    chk({jabber, link_pulse, break_link, tx_allowed}, 4'h1);
  endtask
  task automatic t_nlp();
    restart();
    mode_10 = 1;
    till(0, 1);
    till(0, 0);
    chk(n, PW);
    till(0, 1);
    chk(n + PW, NLP);
    $display("nlp test done");
  endtask
  task automatic t_flp();
    logic p;
    restart();
    autoneg_en = 1;
    till(0, 1);
    p = 1;
    q = {};
    for (int t = 1; t <= FPER; t++) begin
      @(negedge mclk);
      if (t == FCLK) chk(burst_active, 1);
      if (t == 17 * FCLK) chk(burst_active, 0);
      if (link_pulse && !p) q.push_back(t);
      p = link_pulse;
    end
    n = 0;
    for (int k = 0; k <= 16; k++) begin
      if (k > 0) chk(q[n++], k * FCLK);
      if (k < 16 && code_word[k]) chk(q[n++], k * FCLK + FDAT);
    end
    chk(q[n], FPER);
    chk(q.size(), n + 1);
    $display("flp test done");
  endtask
  task automatic t_jab();
    restart();
    mode_10 = 1;
    tx_active = 1;
    till(1, 1);
    chk(n, JON + 2);
    chk(tx_allowed, 0);
    till(1, 0);
    chk(n, JOFF);
    chk(tx_allowed, 1);
    $display("jabber test done");
  endtask
  task automatic t_brk();
    restart();
    autoneg_en = 1;
    till(0, 1);
    till(0, 0);
    renegotiate = 1;
    @(negedge mclk) renegotiate = 0;
    chk({break_link, tx_allowed, burst_active}, 3'h4);
    n = 0;
    repeat (BRK - 10) @(negedge mclk) n += link_pulse;
    chk(n, 0);
    till(2, 0);
    till(0, 1);
    chk(n < 3, 1);
    $display("break test done");
  endtask
  task automatic t_sd();
    restart();
    mode_100 = 1;
    sig_on = 1;
    till(3, 1);
    chk(n, EON + 2);
    sig_on = 0;
    till(3, 0);
    chk(n, EOFF + 2);
    $display("detect test done");
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    t_nlp();
    t_flp();
    t_jab();
    t_brk();
    t_sd();
    complete_run();
  end
endmodule // link_pulse_jabber_timers_tb
